// ==== pkg/ext_instr_params.svh ====
`ifndef EXT_INSTR_PARAMS_SVH
`define EXT_INSTR_PARAMS_SVH
`define DATA_W         8
`define DADDR_W        9
`define PADDR_W        16
`define PWORD_W        16
`define ACC_RST        8'h00
`define PTR_RST        8'h00
`define LATCH_RST      8'h00
`define ZERO_BYTE      8'h00
`define LAST_PAGE      8'hFF
`define SKIP_CYCLES    3
`define NORMAL_CYCLES  2
`endif

// ==== pkg/ext_instr_pkg.sv ====
package ext_instr_pkg;
    typedef enum logic [3:0] {
        OP_NONE              = 4'h0,
        OP_MEM_NIBBLE_SWAP   = 4'h1,
        OP_NIBBLE_SWAP_ACC   = 4'h2,
        OP_SKIP_BYTE_ZERO    = 4'h3,
        OP_SKIP_ZERO_MOVE    = 4'h4,
        OP_SKIP_BIT_ZERO     = 4'h5,
        OP_TABLE_PAGED       = 4'h6,
        OP_TABLE_LAST        = 4'h7,
        OP_TABLE_PAGED_INC   = 4'h8,
        OP_TABLE_LAST_INC    = 4'h9,
        OP_XOR_ACC           = 4'hA,
        OP_XOR_MEM           = 4'hB
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_WRITE = 2'b10,
        ST_DUMMY = 2'b11
    } state_e;
endpackage

// ==== src/ext_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_instr_params.svh"
module ext_alu
    import ext_instr_pkg::*;
#(
    parameter int DW = `DATA_W
)
(
    input  wire logic [3:0]    op,
    input  wire logic [DW-1:0] memByte,
    input  wire logic [DW-1:0] acc,
    input  wire logic [2:0]    bitSel,
    output logic      [DW-1:0] swapped,
    output logic      [DW-1:0] xorResult,
    output logic               xorZero,
    output logic               skipCond
);
    localparam int HALF = DW / 2;

    always_comb
    begin
        swapped   = {memByte[HALF-1:0], memByte[DW-1:HALF]};
        xorResult = acc ^ memByte;
        xorZero   = (xorResult == DW'(`ZERO_BYTE));
        unique case (op)
            OP_SKIP_BYTE_ZERO, OP_SKIP_ZERO_MOVE:
                skipCond = (memByte == DW'(`ZERO_BYTE));
            OP_SKIP_BIT_ZERO:
                skipCond = ~memByte[bitSel];
            default:
                skipCond = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ==== src/ext_instr_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_instr_params.svh"
module ext_instr_exec
    import ext_instr_pkg::*;
#(
    parameter int DW  = `DATA_W,
    parameter int DAW = `DADDR_W,
    parameter int PAW = `PADDR_W,
    parameter int PWW = `PWORD_W
)
(
    input  wire logic           clk_sys,
    input  wire logic           sys_rst,
    input  wire logic           instrValid,
    input  wire logic [3:0]     instrOp,
    input  wire logic [DAW-1:0] instrAddr,
    input  wire logic [2:0]     instrBit,
    output logic                instrReady,
    output logic                skipTaken,
    output logic                dummyCycle,
    output logic [DAW-1:0]      dmemAddr,
    output logic                dmemRead,
    input  wire logic [DW-1:0]  dmemRdata,
    output logic                dmemWrite,
    output logic [DW-1:0]       dmemWdata,
    output logic [PAW-1:0]      pmemAddr,
    output logic                pmemRead,
    input  wire logic [PWW-1:0] pmemRdata,
    input  wire logic           ptrLowLoad,
    input  wire logic           ptrHighLoad,
    input  wire logic [DW-1:0]  ptrLoadData,
    output logic [DW-1:0]       accumulator,
    output logic                zeroFlag,
    output logic [DW-1:0]       table_high_latch,
    output logic [DW-1:0]       table_ptr_low,
    output logic [DW-1:0]       table_ptr_high
);
    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    state_e        state;
    state_e        next_state;
    logic [3:0]    op;
    logic [3:0]    next_op;
    logic [DAW-1:0] addr;
    logic [DAW-1:0] next_addr;
    logic [2:0]    bitSel;
    logic [2:0]    next_bitSel;
    logic [DW-1:0] next_accumulator;
    logic          next_zeroFlag;
    logic [DW-1:0] next_table_high_latch;
    logic [DW-1:0] next_table_ptr_low;
    logic [DW-1:0] next_table_ptr_high;
    logic [DW-1:0] wdata;
    logic [DW-1:0] next_wdata;
    logic          wr;
    logic          next_wr;
    logic          skipPend;
    logic          next_skipPend;

    logic [DW-1:0] swapped;
    logic [DW-1:0] xorResult;
    logic          xorZero;
    logic          skipCond;

    ext_alu #(.DW(DW)) alu
    (
        .op        (op),
        .memByte   (dmemRdata),
        .acc       (accumulator),
        .bitSel    (bitSel),
        .swapped   (swapped),
        .xorResult (xorResult),
        .xorZero   (xorZero),
        .skipCond  (skipCond)
    );

    wire isTable   = (op == OP_TABLE_PAGED) || (op == OP_TABLE_LAST)
                   || (op == OP_TABLE_PAGED_INC) || (op == OP_TABLE_LAST_INC);
    wire isLast    = (op == OP_TABLE_LAST) || (op == OP_TABLE_LAST_INC);

    always_comb
    begin
        next_state            = state;
        next_op               = op;
        next_addr             = addr;
        next_bitSel           = bitSel;
        next_accumulator      = accumulator;
        next_zeroFlag         = zeroFlag;
        next_table_high_latch = table_high_latch;
        next_table_ptr_low    = table_ptr_low;
        next_table_ptr_high   = table_ptr_high;
        next_wdata            = wdata;
        next_wr               = 1'b0;
        next_skipPend         = 1'b0;
        unique case (state)
            ST_IDLE:
            begin
                if (ptrLowLoad)
                    next_table_ptr_low = ptrLoadData;
                if (ptrHighLoad)
                    next_table_ptr_high = ptrLoadData;
                if (instrValid)
                begin
                    next_op     = instrOp;
                    next_addr   = instrAddr;
                    next_bitSel = instrBit;
                    next_state  = ST_EXEC;
                    // Pre-increment wraps inside the low byte only.
                    if (instrOp == OP_TABLE_PAGED_INC || instrOp == OP_TABLE_LAST_INC)
                        next_table_ptr_low = table_ptr_low + DW'(1);
                end
            end
            ST_EXEC:
            begin
                next_state = ST_WRITE;
                unique case (op)
                    OP_MEM_NIBBLE_SWAP:
                    begin
                        next_wdata = swapped;
                        next_wr    = 1'b1;
                    end
                    OP_NIBBLE_SWAP_ACC:
                        next_accumulator = swapped;
                    OP_SKIP_BYTE_ZERO:
                    begin
                        next_wdata    = dmemRdata;
                        next_wr       = 1'b1;
                        next_skipPend = skipCond;
                    end
                    OP_SKIP_ZERO_MOVE:
                    begin
                        next_accumulator = dmemRdata;
                        next_skipPend    = skipCond;
                    end
                    OP_SKIP_BIT_ZERO:
                        next_skipPend = skipCond;
                    OP_XOR_ACC:
                    begin
                        next_accumulator = xorResult;
                        next_zeroFlag    = xorZero;
                    end
                    OP_XOR_MEM:
                    begin
                        next_wdata    = xorResult;
                        next_wr       = 1'b1;
                        next_zeroFlag = xorZero;
                    end
                    default:
                    begin
                        if (isTable)
                        begin
                            next_wdata            = pmemRdata[DW-1:0];
                            next_wr               = 1'b1;
                            next_table_high_latch = pmemRdata[PWW-1:DW];
                        end
                    end
                endcase
            end
            ST_WRITE:
                next_state = skipPend ? ST_DUMMY : ST_IDLE;
            ST_DUMMY:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state            <= ST_IDLE;
            op               <= OP_NONE;
            addr             <= '0;
            bitSel           <= 3'h0;
            accumulator      <= `ACC_RST;
            zeroFlag         <= 1'b0;
            table_high_latch <= `LATCH_RST;
            table_ptr_low    <= `PTR_RST;
            table_ptr_high   <= `PTR_RST;
            wdata            <= `ZERO_BYTE;
            wr               <= 1'b0;
            skipPend         <= 1'b0;
        end
        else
        begin
            state            <= next_state;
            op               <= next_op;
            addr             <= next_addr;
            bitSel           <= next_bitSel;
            accumulator      <= next_accumulator;
            zeroFlag         <= next_zeroFlag;
            table_high_latch <= next_table_high_latch;
            table_ptr_low    <= next_table_ptr_low;
            table_ptr_high   <= next_table_ptr_high;
            wdata            <= next_wdata;
            wr               <= next_wr;
            skipPend         <= next_skipPend;
        end
    end

    // ----------------------------------------------------------------
    // Memory ports
    // ----------------------------------------------------------------
    assign instrReady = (state == ST_IDLE);
    assign dmemAddr   = addr;
    assign dmemRead   = (state == ST_EXEC) && !isTable;
    assign dmemWrite  = (state == ST_WRITE) && wr;
    assign dmemWdata  = wdata;
    assign pmemRead   = (state == ST_EXEC) && isTable;
    assign pmemAddr   = {(isLast ? DW'(`LAST_PAGE) : table_ptr_high), table_ptr_low};
    assign skipTaken  = (state == ST_WRITE) && skipPend;
    assign dummyCycle = (state == ST_DUMMY);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    swap_mem_a: assert property ((state == ST_EXEC && op == OP_MEM_NIBBLE_SWAP)
        |=> dmemWrite && dmemWdata == {$past(dmemRdata[3:0]), $past(dmemRdata[7:4])})
        else $error("nibble swap wrote wrong value");
    swap_acc_a: assert property ((state == ST_EXEC && op == OP_NIBBLE_SWAP_ACC)
        |=> !dmemWrite && accumulator == {$past(dmemRdata[3:0]), $past(dmemRdata[7:4])})
        else $error("swap to accumulator wrong");
    skip_write_a: assert property ((state == ST_EXEC && op == OP_SKIP_BYTE_ZERO)
        |=> dmemWrite && dmemWdata == $past(dmemRdata))
        else $error("skip test did not rewrite byte");
    skip_zero_a: assert property ((state == ST_EXEC && op == OP_SKIP_BYTE_ZERO && dmemRdata == 8'h00)
        |=> skipTaken ##1 dummyCycle ##1 instrReady)
        else $error("zero byte did not skip");
    skip_len_a: assert property ($fell(instrReady) ##1 skipTaken
        |=> dummyCycle ##1 instrReady)
        else $error("skip without dummy cycle");
    move_acc_a: assert property ((state == ST_EXEC && op == OP_SKIP_ZERO_MOVE)
        |=> accumulator == $past(dmemRdata) && skipTaken == ($past(dmemRdata) == 8'h00))
        else $error("move skip wrong");
    bit_skip_a: assert property ((state == ST_EXEC && op == OP_SKIP_BIT_ZERO)
        |=> skipTaken == !$past(dmemRdata[bitSel]))
        else $error("bit skip wrong");
    table_rd_a: assert property ((state == ST_EXEC && isTable)
        |=> dmemWrite && table_high_latch == $past(pmemRdata[15:8]) && $stable(zeroFlag))
        else $error("table read data wrong");
    last_page_a: assert property (pmemRead && isLast |-> pmemAddr[15:8] == 8'hFF)
        else $error("last page address wrong");
    ptr_inc_a: assert property ((instrReady && instrValid && instrOp == OP_TABLE_PAGED_INC)
        |=> table_ptr_low == $past(table_ptr_low) + 8'h01 && $stable(table_ptr_high))
        else $error("pointer increment wrong");
    ptr_last_a: assert property ((instrReady && instrValid && instrOp == OP_TABLE_LAST_INC)
        |=> table_ptr_low == $past(table_ptr_low) + 8'h01)
        else $error("last-page increment wrong");
    xor_acc_a: assert property ((state == ST_EXEC && op == OP_XOR_ACC)
        |=> accumulator == ($past(accumulator) ^ $past(dmemRdata)) && zeroFlag == (accumulator == 8'h00))
        else $error("xor to accumulator wrong");
    xor_mem_a: assert property ((state == ST_EXEC && op == OP_XOR_MEM)
        |=> $stable(accumulator) && dmemWrite && dmemWdata == ($past(accumulator) ^ $past(dmemRdata))
            && zeroFlag == (dmemWdata == 8'h00))
        else $error("xor to memory wrong");

    skip_seen_c:  cover property (skipTaken ##1 dummyCycle);
    table_inc_c:  cover property (pmemRead && op == OP_TABLE_LAST_INC);
    xor_zero_c:   cover property (state == ST_EXEC && op == OP_XOR_MEM && xorZero);
endmodule
`default_nettype wire

// ==== verif/core_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_mem_model
(
    input  wire logic        clk_sys,
    input  wire logic [8:0]  dmemAddr,
    input  wire logic        dmemRead,
    input  wire logic        dmemWrite,
    input  wire logic [7:0]  dmemWdata,
    output logic      [7:0]  dmemRdata,
    input  wire logic [15:0] pmemAddr,
    input  wire logic        pmemRead,
    output logic      [15:0] pmemRdata
);
    logic [7:0]  mem [0:511];
    logic [7:0]  lastD = 8'hA5;
    logic [15:0] lastP = 16'h5AA5;

    // Each word depends on both address bytes, so a wrong page or low byte shows in the data.
    function automatic logic [15:0] wordAt(input logic [15:0] a);
        return {a[7:0] ^ 8'h5A, a[15:8] + 8'h11};
    endfunction

    // Released read lines show the inverse of the last value, so stale data never passes as fresh.
    assign dmemRdata = dmemRead ? mem[dmemAddr] : ~lastD;
    assign pmemRdata = pmemRead ? wordAt(pmemAddr) : ~lastP;

    // A plain process, because the bench preloads this array directly.
    always @(posedge clk_sys)
    begin
        if (dmemRead)
            lastD <= mem[dmemAddr];
        if (pmemRead)
            lastP <= wordAt(pmemAddr);
        if (dmemWrite)
            mem[dmemAddr] <= dmemWdata;
    end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ext_instr_params.svh"
module tb_top
    import ext_instr_pkg::*;
();
    logic        clk_sys, sys_rst, instrValid, instrReady, skipTaken, dummyCycle;
    logic [3:0]  instrOp;
    logic [8:0]  instrAddr, dmemAddr;
    logic [2:0]  instrBit;
    logic        dmemRead, dmemWrite, pmemRead, ptrLowLoad, ptrHighLoad, zeroFlag;
    logic [7:0]  dmemRdata, dmemWdata, ptrLoadData, accumulator;
    logic [7:0]  table_high_latch, table_ptr_low, table_ptr_high, seenWdata;
    logic [15:0] pmemAddr, pmemRdata;
    logic        seenSkip, seenDummy, seenWrite;
    int          n_errors = 0;
    int          checks = 0;
    int          lows;

    ext_instr_exec i_ext_instr_exec (.clk_sys(clk_sys), .sys_rst(sys_rst), .instrValid(instrValid),
        .instrOp(instrOp), .instrAddr(instrAddr), .instrBit(instrBit), .instrReady(instrReady),
        .skipTaken(skipTaken), .dummyCycle(dummyCycle), .dmemAddr(dmemAddr), .dmemRead(dmemRead),
        .dmemRdata(dmemRdata), .dmemWrite(dmemWrite), .dmemWdata(dmemWdata), .pmemAddr(pmemAddr),
        .pmemRead(pmemRead), .pmemRdata(pmemRdata), .ptrLowLoad(ptrLowLoad), .ptrHighLoad(ptrHighLoad),
        .ptrLoadData(ptrLoadData), .accumulator(accumulator), .zeroFlag(zeroFlag),
        .table_high_latch(table_high_latch), .table_ptr_low(table_ptr_low), .table_ptr_high(table_ptr_high));

    core_mem_model i_core_mem_model (.clk_sys(clk_sys), .dmemAddr(dmemAddr), .dmemRead(dmemRead),
        .dmemWrite(dmemWrite), .dmemWdata(dmemWdata), .dmemRdata(dmemRdata), .pmemAddr(pmemAddr),
        .pmemRead(pmemRead), .pmemRdata(pmemRdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
        checks++;
        if (got !== expv)
        begin
            $display("mismatch %s expected %h seen %h", what, expv, got);
            n_errors++;
        end
    endtask

    // Offers one instruction at a falling edge and follows it until the block is idle again.
    task automatic run(input op_e op, input logic [8:0] a, input logic [2:0] b, input logic expSkip);
        int i;
        for (i = 0; i < 20 && instrReady !== 1'b1; i++)
            @(negedge clk_sys);
        if (i == 20)
        begin
            n_errors++;
            report_and_stop();
        end
        instrOp = op;
        instrAddr = a;
        instrBit = b;
        instrValid = 1'b1;
        @(negedge clk_sys);
        instrValid = 1'b0;
        {lows, seenSkip, seenDummy, seenWrite} = '0;
        for (i = 0; i < 10 && instrReady !== 1'b1; i++)
        begin
            lows++;
            seenSkip |= (skipTaken === 1'b1);
            seenDummy |= (dummyCycle === 1'b1);
            if (dmemWrite === 1'b1)
                {seenWrite, seenWdata} = {1'b1, dmemWdata};
            @(negedge clk_sys);
        end
        if (i == 10)
        begin
            n_errors++;
            report_and_stop();
        end
        chk("cycles", expSkip ? `SKIP_CYCLES : `NORMAL_CYCLES, lows);
        chk("skip", expSkip, seenSkip);
        chk("dummy", expSkip, seenDummy);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_swap();
        logic z;
        z = zeroFlag;
        i_core_mem_model.mem[9'h105] = 8'h3C;
        run(OP_MEM_NIBBLE_SWAP, 9'h105, 3'h0, 1'b0);
        chk("swap mem", 8'hC3, i_core_mem_model.mem[9'h105]);
        i_core_mem_model.mem[9'h1A0] = 8'h5A;
        run(OP_NIBBLE_SWAP_ACC, 9'h1A0, 3'h0, 1'b0);
        chk("swap acc", 8'hA5, accumulator);
        chk("swap src", 8'h5A, i_core_mem_model.mem[9'h1A0]);
        chk("swap flag", z, zeroFlag);
    endtask

    task automatic t_xor();
        i_core_mem_model.mem[9'h020] = 8'hA5;
        run(OP_XOR_ACC, 9'h020, 3'h0, 1'b0);
        chk("xor acc zero", 9'h001, {accumulator, zeroFlag});
        i_core_mem_model.mem[9'h021] = 8'h0F;
        run(OP_XOR_ACC, 9'h021, 3'h0, 1'b0);
        chk("xor acc", {8'h0F, 1'b0}, {accumulator, zeroFlag});
        i_core_mem_model.mem[9'h022] = 8'hFF;
        run(OP_XOR_MEM, 9'h022, 3'h0, 1'b0);
        chk("xor mem", 8'hF0, i_core_mem_model.mem[9'h022]);
        chk("xor mem acc", {8'h0F, 1'b0}, {accumulator, zeroFlag});
        i_core_mem_model.mem[9'h023] = 8'h0F;
        run(OP_XOR_MEM, 9'h023, 3'h0, 1'b0);
        chk("xor mem zero", 9'h000, {i_core_mem_model.mem[9'h023], ~zeroFlag});
    endtask

    task automatic t_skip();
        int b;
        i_core_mem_model.mem[9'h040] = 8'h00;
        i_core_mem_model.mem[9'h041] = 8'h80;
        run(OP_SKIP_BYTE_ZERO, 9'h040, 3'h0, 1'b1);
        chk("skip wback", 9'h100, {seenWrite, seenWdata});
        run(OP_SKIP_BYTE_ZERO, 9'h041, 3'h0, 1'b0);
        chk("noskip wback", 9'h180, {seenWrite, seenWdata});
        run(OP_SKIP_ZERO_MOVE, 9'h041, 3'h0, 1'b0);
        chk("move acc", {8'h80, 1'b1}, {accumulator, zeroFlag});
        run(OP_SKIP_ZERO_MOVE, 9'h040, 3'h0, 1'b1);
        chk("move zero", {8'h00, 1'b1}, {accumulator, zeroFlag});
        i_core_mem_model.mem[9'h044] = 8'h55;
        for (b = 0; b < 8; b++)
            run(OP_SKIP_BIT_ZERO, 9'h044, b[2:0], b[0]);
        chk("bit flag", 1'b1, zeroFlag);
    endtask

    task automatic t_table();
        op_e         ops [4] = '{OP_TABLE_PAGED, OP_TABLE_LAST, OP_TABLE_PAGED_INC, OP_TABLE_LAST_INC};
        logic [15:0] adr [4] = '{16'h12FF, 16'hFFFF, 16'h1200, 16'hFF01};
        logic [15:0] ptr [4] = '{16'h12FF, 16'h12FF, 16'h1200, 16'h1201};
        logic [15:0] w;
        int          k;
        ptrLowLoad = 1'b1;
        ptrLoadData = 8'hFF;
        @(negedge clk_sys);
        {ptrLowLoad, ptrHighLoad, ptrLoadData} = {2'b01, 8'h12};
        @(negedge clk_sys);
        ptrHighLoad = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            w = i_core_mem_model.wordAt(adr[k]);
            run(ops[k], 9'h080 + 9'(k), 3'h0, 1'b0);
            chk("table ptr", ptr[k], {table_ptr_high, table_ptr_low});
            chk("table low", w[7:0], i_core_mem_model.mem[9'h080 + 9'(k)]);
            chk("table high", w[15:8], table_high_latch);
            chk("table flag", 1'b1, zeroFlag);
        end
    endtask

    initial
    begin
        {sys_rst, instrValid, instrOp, instrAddr, instrBit} = {1'b1, 17'h0};
        {ptrLowLoad, ptrHighLoad, ptrLoadData} = '0;
        repeat (4) @(negedge clk_sys);
        chk("reset regs", 16'h0000, {accumulator, table_high_latch});
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_swap();
        t_xor();
        t_skip();
        t_table();
        report_and_stop();
    end
endmodule
`default_nettype wire
